// >>> src/dim_defs.vh
`ifndef DIM_DEFS_VH
`define DIM_DEFS_VH

// Address and data shape of the memory system.
`define DIM_SYS_AW        13
`define DIM_LOC_AW        10
`define DIM_DW            16
`define DIM_ID_W          3

// Identity field position inside the system address.
`define DIM_ID_MSB        12
`define DIM_ID_LSB        10

// Identity values that bound the regions of the memory map.
`define DIM_ID_PROG_LAST  3'h4
`define DIM_ID_FILT       3'h5
`define DIM_ID_HIT        3'h6

// Region codes reported by the chip.
`define DIM_REG_PROG      2'h0
`define DIM_REG_FILT      2'h1
`define DIM_REG_HIT       2'h2
`define DIM_REG_NONE      2'h3

// Configuration port offsets.
`define DIM_CFG_AW        2
`define DIM_OFS_CTRL      2'h0
`define DIM_OFS_STAT      2'h1
`define DIM_OFS_SEQ       2'h2
`define DIM_OFS_ID        2'h3

// Control register field positions.
`define DIM_CTRL_SEL_BIT  0
`define DIM_CTRL_CLR_BIT  1

// Status register field positions.
`define DIM_STAT_BUSY_BIT 0
`define DIM_STAT_ALT_BIT  1
`define DIM_STAT_REG_LSB  2
`define DIM_STAT_PEND_BIT 4

// Reset values.
`define DIM_RST_SEL       1'h0
`define DIM_RST_WORD      16'h0000
`define DIM_RST_SEQ       10'h000
`define DIM_RST_BITS      4'h0

// Serial word assembly: index of the last bit of a word.
`define DIM_SER_LAST      4'hf

`endif

// >>> src/dim_ram.v
`timescale 1ns/1ps

// Single-port word store with a registered read port.
module dim_ram #(
    parameter AW = 10,
    parameter DW = 16
) (
    input  wire          clk_i,
    input  wire          ce_i,
    input  wire          we_i,
    input  wire          re_i,
    input  wire [AW-1:0] addr_i,
    input  wire [DW-1:0] wdata_i,
    output reg  [DW-1:0] rdata_o
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Storage has no reset; read data appear one cycle after the read strobe.
    always @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[addr_i] <= wdata_i;
            end
            if (re_i) begin
                rdata_o <= mem[addr_i];
            end
        end
    end

endmodule // dim_ram

// >>> src/dim_chip.v
`timescale 1ns/1ps
`include "dim_defs.vh"

module dim_chip #(
    parameter                 SAW     = `DIM_SYS_AW,
    parameter                 LAW     = `DIM_LOC_AW,
    parameter                 DW      = `DIM_DW,
    parameter [`DIM_ID_W-1:0] CHIP_ID = 3'h0,
    parameter                 HIT_ALT = 0
) (
    input  wire                   clk_i,
    input  wire                   rst_b_i,
    input  wire                   ce_i,
    input  wire                   mb_en_i,
    input  wire                   mb_wr_i,
    input  wire [SAW-1:0]         mb_addr_i,
    input  wire [DW-1:0]          mb_data_i,
    output reg  [DW-1:0]          mb_data_o,
    output reg                    mb_data_oe_o,
    output reg                    mb_ack_o,
    input  wire [DW-1:0]          alt_par_data_i,
    input  wire                   alt_par_stb_i,
    input  wire                   alt_ser_bit_i,
    input  wire                   alt_ser_stb_i,
    input  wire                   seq_clr_i,
    input  wire                   seq_cnt_en_i,
    input  wire                   sel_toggle_i,
    input  wire [`DIM_CFG_AW-1:0] cfg_addr_i,
    input  wire [DW-1:0]          cfg_wdata_i,
    input  wire                   cfg_wr_i,
    input  wire                   cfg_rd_i,
    output reg  [DW-1:0]          cfg_rdata_o,
    output reg                    sel_o,
    output reg  [1:0]             region_o
);

    localparam P_IDLE = 2'h0;
    localparam P_WAIT = 2'h1;
    localparam P_HOLD = 2'h2;

    // True when the identity field of a system address names this chip.
    // only the identity field compared
    function id_hit;
        input [SAW-1:0] addr;
        begin
            id_hit = (addr[`DIM_ID_MSB:`DIM_ID_LSB] == CHIP_ID);
        end
    endfunction

    // Region of the memory map that an identity value falls into.
    function [1:0] region_of;
        input [`DIM_ID_W-1:0] id;
        begin
            if (id <= `DIM_ID_PROG_LAST) begin
                region_of = `DIM_REG_PROG;
            end else if (id == `DIM_ID_FILT) begin
                region_of = `DIM_REG_FILT;
            end else if (id == `DIM_ID_HIT) begin
                region_of = `DIM_REG_HIT;
            end else begin
                region_of = `DIM_REG_NONE;
            end
        end
    endfunction

    // Alternate-side pins come from other equipment, so each passes two flops.
    reg [DW-1:0] par_data_s1_q;
    reg [DW-1:0] par_data_s2_q;
    reg [4:0]    pin_s1_q;
    reg [4:0]    pin_s2_q;
    reg [4:0]    pin_s3_q;

    reg [1:0]    p_state_q;
    reg          sel_q;
    reg [LAW-1:0] seq_q;
    reg [DW-2:0] ser_shift_q;
    reg [3:0]    ser_bits_q;
    reg [DW-1:0] ser_word_q;
    reg          ser_pend_q;

    wire [DW-1:0] ram_rdata;
    wire          par_stb_s;
    wire          ser_stb_s;
    wire          ser_bit_s;
    wire          clr_s;
    wire          par_edge;
    wire          ser_edge;
    wire          cnt_edge;
    wire          tog_edge;
    wire          alt_mode;
    wire          mb_go;
    wire          prim_we;
    wire          prim_re;
    wire          alt_we;
    wire          ram_we;
    wire          ram_re;
    wire [LAW-1:0] ram_addr;
    wire [DW-1:0]  ram_wdata;
    wire          cfg_clr;
    wire          ser_done;

    // Pin order: par strobe, serial strobe, serial bit, counter clear, count enable.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            par_data_s1_q <= `DIM_RST_WORD;
            par_data_s2_q <= `DIM_RST_WORD;
            pin_s1_q      <= 5'h00;
            pin_s2_q      <= 5'h00;
            pin_s3_q      <= 5'h00;
        end else if (ce_i) begin
            par_data_s1_q <= alt_par_data_i;
            par_data_s2_q <= par_data_s1_q;
            pin_s1_q      <= {seq_cnt_en_i, seq_clr_i, alt_ser_bit_i, alt_ser_stb_i, alt_par_stb_i};
            pin_s2_q      <= pin_s1_q;
            pin_s3_q      <= pin_s2_q;
        end
    end

    // The toggle line has its own synchroniser so its edge is seen once.
    reg tog_s1_q;
    reg tog_s2_q;
    reg tog_s3_q;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            tog_s1_q <= 1'h0;
            tog_s2_q <= 1'h0;
            tog_s3_q <= 1'h0;
        end else if (ce_i) begin
            tog_s1_q <= sel_toggle_i;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // Rising edges of the synchronised strobes; each is one cycle long.
    assign par_stb_s = pin_s2_q[0];
    assign ser_stb_s = pin_s2_q[1];
    assign ser_bit_s = pin_s2_q[2];
    assign clr_s     = pin_s2_q[3];
    assign par_edge  = par_stb_s & ~pin_s3_q[0];
    assign ser_edge  = ser_stb_s & ~pin_s3_q[1];
    assign cnt_edge  = pin_s2_q[4] & ~pin_s3_q[4];
    assign tog_edge  = tog_s2_q & ~tog_s3_q;

    assign alt_mode = sel_q ^ (HIT_ALT != 0);

    assign mb_go = mb_en_i & id_hit(mb_addr_i) & ~alt_mode & (p_state_q == P_IDLE);

    assign prim_we = mb_go & mb_wr_i;
    assign prim_re = mb_go & ~mb_wr_i;

    assign alt_we    = alt_mode & (par_edge | ser_pend_q);

    assign ram_we    = alt_mode ? alt_we : prim_we;
    assign ram_re    = prim_re;
    assign ram_addr  = alt_mode ? seq_q : mb_addr_i[LAW-1:0];
    assign ram_wdata = alt_mode ? (par_edge ? par_data_s2_q : ser_word_q) : mb_data_i;

    assign cfg_clr  = cfg_wr_i & (cfg_addr_i == `DIM_OFS_CTRL) & cfg_wdata_i[`DIM_CTRL_CLR_BIT];
    assign ser_done = alt_mode & ser_edge & (ser_bits_q == `DIM_SER_LAST);

    dim_ram #(
        .AW (LAW),
        .DW (DW)
    ) u_ram (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (ram_we),
        .re_i    (ram_re),
        .addr_i  (ram_addr),
        .wdata_i (ram_wdata),
        .rdata_o (ram_rdata)
    );

    // Primary handshake: a read takes one extra cycle for the registered store.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            p_state_q    <= P_IDLE;
            mb_ack_o     <= 1'h0;
            mb_data_oe_o <= 1'h0;
            mb_data_o    <= `DIM_RST_WORD;
        end else if (ce_i) begin
            case (p_state_q)
                P_IDLE: begin
                    if (prim_we) begin
                        mb_ack_o  <= 1'h1;
                        p_state_q <= P_HOLD;
                    end else if (prim_re) begin
                        p_state_q <= P_WAIT;
                    end
                end
                P_WAIT: begin
                    if (!mb_en_i || alt_mode) begin
                        p_state_q <= P_IDLE;
                    end else begin
                        mb_data_o    <= ram_rdata;
                        mb_data_oe_o <= 1'h1;
                        mb_ack_o     <= 1'h1;
                        p_state_q    <= P_HOLD;
                    end
                end
                P_HOLD: begin
                    if (!mb_en_i || alt_mode) begin
                        mb_ack_o     <= 1'h0;
                        mb_data_oe_o <= 1'h0;
                        p_state_q    <= P_IDLE;
                    end
                end
                default: begin
                    mb_ack_o     <= 1'h0;
                    mb_data_oe_o <= 1'h0;
                    p_state_q    <= P_IDLE;
                end
            endcase
        end
    end

    // Select flip-flop: a toggle edge wins over a software write in the same cycle.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            sel_q <= `DIM_RST_SEL;
        end else if (ce_i) begin
            if (tog_edge) begin
                sel_q <= ~sel_q;
            end else if (cfg_wr_i && (cfg_addr_i == `DIM_OFS_CTRL)) begin
                sel_q <= cfg_wdata_i[`DIM_CTRL_SEL_BIT];
            end
        end
    end

    // Sequence counter; a clear from either source beats a count step.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            seq_q <= `DIM_RST_SEQ;
        end else if (ce_i) begin
            if (cfg_clr || (alt_mode && clr_s)) begin
                seq_q <= `DIM_RST_SEQ;
            end else if (alt_mode && cnt_edge) begin
                seq_q <= seq_q + {{(LAW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Serial assembly, first bit lands in the top of the word.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ser_shift_q <= {(DW-1){1'b0}};
            ser_bits_q  <= `DIM_RST_BITS;
            ser_word_q  <= `DIM_RST_WORD;
        end else if (ce_i) begin
            if (!alt_mode) begin
                ser_bits_q <= `DIM_RST_BITS;
            end else if (ser_edge) begin
                ser_shift_q <= {ser_shift_q[DW-3:0], ser_bit_s};
                ser_bits_q  <= ser_bits_q + 4'h1;
                if (ser_done) begin
                    ser_word_q <= {ser_shift_q, ser_bit_s};
                end
            end
        end
    end

    // A finished serial word waits while a parallel word owns the store port.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ser_pend_q <= 1'h0;
        end else if (ce_i) begin
            if (ser_done) begin
                ser_pend_q <= 1'h1;
            end else if (!alt_mode || (ser_pend_q && !par_edge)) begin
                ser_pend_q <= 1'h0;
            end
        end
    end

    // Configuration reads answer one cycle later; all four offsets are mapped.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cfg_rdata_o <= `DIM_RST_WORD;
        end else if (ce_i) begin
            if (cfg_rd_i) begin
                case (cfg_addr_i)
                    `DIM_OFS_CTRL: cfg_rdata_o <= {{(DW-1){1'b0}}, sel_q};
                    `DIM_OFS_STAT: cfg_rdata_o <= {{(DW-5){1'b0}}, ser_pend_q, region_o,
                                                   alt_mode, (p_state_q != P_IDLE)};
                    `DIM_OFS_SEQ:  cfg_rdata_o <= {{(DW-LAW){1'b0}}, seq_q};
                    default:       cfg_rdata_o <= {{(DW-`DIM_ID_W){1'b0}}, CHIP_ID};
                endcase
            end else begin
                cfg_rdata_o <= `DIM_RST_WORD;
            end
        end
    end

    // Exported select and region, both registered.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            sel_o    <= `DIM_RST_SEL;
            region_o <= `DIM_REG_PROG;
        end else if (ce_i) begin
            sel_o    <= alt_mode;
            region_o <= region_of(CHIP_ID);
        end
    end

endmodule // dim_chip

// >>> tb/dim_chip_properties.sv
`timescale 1ns/1ps
`include "dim_defs.vh"
// Watches the primary bus handshake and the identity read of one chip.
module dim_chip_properties #(
    parameter [2:0] CHIP_ID = 3'h0
) (
    input logic        clk_i,
    input logic        rst_b_i,
    input logic        mb_en_i,
    input logic        mb_wr_i,
    input logic [12:0] mb_addr_i,
    input logic        mb_data_oe_o,
    input logic        mb_ack_o,
    input logic [1:0]  cfg_addr_i,
    input logic        cfg_rd_i,
    input logic [15:0] cfg_rdata_o,
    input logic        sel_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // A request counts only when the identity matches and the primary side is live.
    wire id_ok = (mb_addr_i[12:10] == CHIP_ID) && !sel_o;
    write_ack_a: assert property ($rose(mb_en_i) && mb_wr_i && id_ok && !mb_ack_o |=> mb_ack_o)
        else $error("write not acknowledged after one cycle");
    read_ack_a: assert property ($rose(mb_en_i) && !mb_wr_i && id_ok && !mb_ack_o |=> !mb_ack_o ##1 (mb_ack_o && mb_data_oe_o))
        else $error("read answer not two cycles after enable");
    ack_hold_a: assert property (mb_ack_o && mb_en_i && !sel_o |=> mb_ack_o || sel_o)
        else $error("acknowledge dropped while enable high");
    ack_drop_a: assert property (!mb_en_i |=> !mb_ack_o && !mb_data_oe_o)
        else $error("acknowledge or bus drive outlived enable");
    ack_cause_a: assert property ($rose(mb_ack_o) |-> mb_en_i && (mb_addr_i[12:10] == CHIP_ID))
        else $error("acknowledge without identity match");
    oe_ack_a: assert property (mb_data_oe_o |-> mb_ack_o && !mb_wr_i)
        else $error("bus driven outside a read answer");
    alt_block_a: assert property ($rose(mb_ack_o) |-> !sel_o)
        else $error("primary answered in alternate mode");
    cfg_id_a: assert property (cfg_rd_i && (cfg_addr_i == `DIM_OFS_ID) |=> cfg_rdata_o == {13'h0000, CHIP_ID})
        else $error("identity read wrong");
    cov_wr_c: cover property (mb_en_i && mb_wr_i && mb_ack_o);
    cov_rd_c: cover property (mb_data_oe_o);
    cov_alt_c: cover property ($rose(sel_o));
endmodule // dim_chip_properties

bind dim_chip dim_chip_properties #(.CHIP_ID(CHIP_ID)) i_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .mb_en_i(mb_en_i), .mb_wr_i(mb_wr_i), .mb_addr_i(mb_addr_i),
    .mb_data_oe_o(mb_data_oe_o), .mb_ack_o(mb_ack_o), .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_rdata_o(cfg_rdata_o), .sel_o(sel_o)
);

// >>> tb/dim_node_model.sv
`timescale 1ns/1ps
// Node processor: random access on the primary bus of the memory chips.
module dim_node_model (
    input  logic        clk_i,
    input  logic        mb_ack_i,
    input  logic [15:0] mb_rdata_i,
    output logic        mb_en_o,
    output logic        mb_wr_o,
    output logic [12:0] mb_addr_o,
    output logic [15:0] mb_wdata_o
);
    // Idle bus at time zero.
    initial begin
        mb_en_o = 1'b0;
        mb_wr_o = 1'b0;
        mb_addr_o = 13'h0000;
        mb_wdata_o = 16'h0000;
    end
    // One access; the wait is bounded so that a refused access still returns.
    task automatic access(input logic wr, input logic [12:0] base, input logic [12:0] idx, input logic [15:0] wd,
                          input int hold, output logic [15:0] rd, output logic acked);
        int n;
        n = 0;
        acked = 1'b0;
        @(posedge clk_i);
        mb_wr_o <= wr;
        mb_addr_o <= base + idx;
        mb_wdata_o <= wr ? wd : ~mb_wdata_o;
        @(posedge clk_i);
        mb_en_o <= 1'b1;
        while (!acked && n < 12) begin
            @(posedge clk_i);
            n++;
            acked = (mb_ack_i === 1'b1);
        end
        rd = mb_rdata_i;
        // A slow processor keeps enable up after the answer.
        repeat (hold) @(posedge clk_i);
        mb_en_o <= 1'b0;
        mb_wdata_o <= ~mb_wdata_o;
    endtask
endmodule // dim_node_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "dim_defs.vh"
module tb_top;
    localparam [2:0] ID = 3'h5;
    logic        clk_i, rst_b_i, mb_en, mb_wr, mb_oe, mb_ack, ser_bit, cfg_wr, cfg_rd, sel, sel_b;
    logic [12:0] mb_addr;
    logic [15:0] mb_wd, mb_rd, par_data, cfg_wd, cfg_rdata, rd;
    logic [4:0]  pins;
    logic [1:0]  cfg_addr, region, region_b;
    int          n_errors, tests_run, cyc;

    dim_node_model i_node (.clk_i(clk_i), .mb_ack_i(mb_ack), .mb_rdata_i(mb_rd), .mb_en_o(mb_en),
        .mb_wr_o(mb_wr), .mb_addr_o(mb_addr), .mb_wdata_o(mb_wd));
    dim_chip #(.CHIP_ID(ID)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .mb_en_i(mb_en),
        .mb_wr_i(mb_wr), .mb_addr_i(mb_addr), .mb_data_i(mb_wd), .mb_data_o(mb_rd), .mb_data_oe_o(mb_oe),
        .mb_ack_o(mb_ack), .alt_par_data_i(par_data), .alt_par_stb_i(pins[0]), .alt_ser_bit_i(ser_bit),
        .alt_ser_stb_i(pins[1]), .seq_clr_i(pins[2]), .seq_cnt_en_i(pins[3]), .sel_toggle_i(pins[4]),
        .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wd), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
        .cfg_rdata_o(cfg_rdata), .sel_o(sel), .region_o(region));
    // Second chip of the hit pair: same pins, inverted select sense, so it swaps roles with each toggle.
    dim_chip #(.CHIP_ID(`DIM_ID_HIT), .HIT_ALT(1)) i_dut_pair (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
        .mb_en_i(mb_en), .mb_wr_i(mb_wr), .mb_addr_i(mb_addr), .mb_data_i(mb_wd), .mb_data_o(), .mb_data_oe_o(),
        .mb_ack_o(), .alt_par_data_i(par_data), .alt_par_stb_i(pins[0]), .alt_ser_bit_i(ser_bit),
        .alt_ser_stb_i(pins[1]), .seq_clr_i(pins[2]), .seq_cnt_en_i(pins[3]), .sel_toggle_i(pins[4]),
        .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wd), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
        .cfg_rdata_o(), .sel_o(sel_b), .region_o(region_b));

    // Free-running clock at 20 MHz.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Cuts a hang short; the whole run needs a few hundred cycles.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("MISMATCH at %0t: timeout", $time);
            wrap_up();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cfg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cfg_addr <= a;
        cfg_wd <= d;
        cfg_wr <= 1'b1;
        @(posedge clk_i);
        cfg_wr <= 1'b0;
    endtask
    task automatic cfg_read(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_i);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge clk_i);
        cfg_rd <= 1'b0;
        #1 d = cfg_rdata;
    endtask
    // Alternate pins are synchronised inside, so each pulse is held four cycles.
    task automatic pulse(input int p);
        @(posedge clk_i);
        pins <= 5'h01 << p;
        repeat (4) @(posedge clk_i);
        pins <= 5'h00;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic mem(input logic wr, input logic [2:0] id, input logic [9:0] w, input logic [15:0] d,
                       input int hold, input logic exp_ack);
        logic ok;
        i_node.access(wr, {id, 10'h000}, {3'h0, w}, d, hold, rd, ok);
        check(16'(ok), 16'(exp_ack));
    endtask
    task automatic t_reset();
        check(16'({mb_ack, mb_oe, sel}), 16'h0000);
        check(16'(region), 16'(`DIM_REG_FILT));
        check(16'(region_b), 16'(`DIM_REG_HIT));
        check(16'(sel_b), 16'h0001);
        cfg_read(`DIM_OFS_ID, rd);
        check(rd, {13'h0000, ID});
    endtask
    task automatic t_primary();
        logic [9:0]  w [3];
        logic [15:0] d [3];
        w = '{10'h000, 10'h3ff, 10'h155};
        d = '{16'h0f0f, 16'hc3a5, 16'h8001};
        for (int i = 0; i < 3; i++) mem(1'b1, ID, w[i], d[i], 0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            mem(1'b0, ID, w[i], 16'h0000, i, 1'b1);
            check(rd, d[i]);
        end
    endtask
    task automatic t_mismatch();
        mem(1'b1, ID ^ 3'h1, 10'h155, 16'hdead, 0, 1'b0);
        mem(1'b0, ID, 10'h155, 16'h0000, 0, 1'b1);
        check(rd, 16'h8001);
    endtask
    task automatic t_parallel();
        cfg_write(`DIM_OFS_CTRL, 16'h0001);
        repeat (4) @(posedge clk_i);
        check(16'(sel), 16'h0001);
        pulse(2);
        par_data <= 16'h1234;
        pulse(0);
        pulse(3);
        par_data <= 16'h5678;
        pulse(0);
        pulse(3);
        cfg_read(`DIM_OFS_SEQ, rd);
        check(rd, 16'h0002);
        mem(1'b0, ID, 10'h000, 16'h0000, 0, 1'b0);
        cfg_write(`DIM_OFS_CTRL, 16'h0000);
        repeat (4) @(posedge clk_i);
        mem(1'b0, ID, 10'h000, 16'h0000, 0, 1'b1);
        check(rd, 16'h1234);
        mem(1'b0, ID, 10'h001, 16'h0000, 0, 1'b1);
        check(rd, 16'h5678);
    endtask
    task automatic t_serial();
        logic [15:0] w;
        w = 16'ha5c3;
        pulse(4);
        check(16'(sel), 16'h0001);
        check(16'(sel_b), 16'h0000);
        cfg_write(`DIM_OFS_CTRL, 16'h0003);
        cfg_read(`DIM_OFS_SEQ, rd);
        check(rd, 16'h0000);
        for (int i = 15; i >= 0; i--) begin
            ser_bit <= w[i];
            pulse(1);
        end
        pulse(4);
        check(16'(sel), 16'h0000);
        check(16'(sel_b), 16'h0001);
        // The parallel word below must be ignored in primary mode.
        par_data <= 16'hbeef;
        pulse(0);
        mem(1'b0, ID, 10'h000, 16'h0000, 0, 1'b1);
        check(rd, w);
        mem(1'b0, ID, 10'h001, 16'h0000, 0, 1'b1);
        check(rd, 16'h5678);
    endtask
    // Main sequence.
    initial begin
        n_errors = 0;
        tests_run = 0;
        cyc = 0;
        rst_b_i = 1'b0;
        {ser_bit, cfg_wr, cfg_rd, pins, cfg_addr} = '0;
        {par_data, cfg_wd} = '0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_primary();
        t_mismatch();
        t_parallel();
        t_serial();
        wrap_up();
    end
endmodule // tb_top
